// ===== ide_cfg_checker.sv
/*
  Port assertions for the IDE function config registers.
  Assumes binding to every ide_function_config_regs instance.
*/
`timescale 1ns/1ps
module ide_cfg_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        cfg_rd,
  input wire logic [7:2]  cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_rdata_valid,
  input wire logic        io_cycle,
  input wire logic        primary_ide_hit,
  input wire logic        secondary_ide_hit,
  input wire logic        subtractive_decode,
  input wire logic        frame_active,
  input wire logic        bus_hold_ack_n,
  input wire logic        burst_stop,
  input wire logic [2:0]  primary_sample_clocks
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_read_valid_pulse: assert property (cfg_rd |=> cfg_rdata_valid)
    else $error("read gave no valid pulse");
  a_valid_without_read: assert property (!cfg_rd |=> !cfg_rdata_valid)
    else $error("valid without a read");
  a_base_fixed_bits: assert property (cfg_rd && cfg_addr == 6'h08 |=>
    cfg_rdata[31:16] == 16'h0000 && cfg_rdata[3:0] == 4'h1)
    else $error("base fixed bits wrong");
  a_stop_needs_frame: assert property (burst_stop |-> frame_active)
    else $error("stop outside a burst");
  a_ack_keeps_burst: assert property (!bus_hold_ack_n [*3] |-> !burst_stop)
    else $error("stop while hold acknowledged");
  a_subtractive_only_free: assert property (subtractive_decode |->
    io_cycle && !primary_ide_hit && !secondary_ide_hit)
    else $error("subtractive beside a hit");
  a_idle_no_decode: assert property (!io_cycle |->
    !primary_ide_hit && !subtractive_decode)
    else $error("decode without io cycle");
  a_sample_in_range: assert property (primary_sample_clocks inside {[2:5]})
    else $error("sample clocks out of range");
  c_read: cover property (cfg_rd ##1 cfg_rdata_valid);
  c_stop: cover property (burst_stop);
  c_primary: cover property (primary_ide_hit);
endmodule : ide_cfg_checker

bind ide_function_config_regs ide_cfg_checker ide_cfg_checker_inst (
  .ref_clk, .rst, .cfg_rd, .cfg_addr, .cfg_rdata, .cfg_rdata_valid,
  .io_cycle, .primary_ide_hit, .secondary_ide_hit, .subtractive_decode,
  .frame_active, .bus_hold_ack_n, .burst_stop, .primary_sample_clocks);

// ===== ide_cfg_pkg.sv
/*
  Constants for the IDE function configuration registers: offsets,
  field positions, reset values and decode addresses.
  Assumes configuration dwords are addressed by cfg_addr[7:2].
*/
package ide_cfg_pkg;

  // Printed byte offsets
  localparam logic [7:0]  LATENCY_OFS     = 8'h0D;
  localparam logic [7:0]  HEADER_TYPE_OFS = 8'h0E;
  localparam logic [7:0]  BM_BASE_OFS     = 8'h20;
  localparam logic [7:0]  PRI_TIM_OFS     = 8'h40;
  localparam logic [7:0]  SEC_TIM_OFS     = 8'h42;

  // Reset and fixed values
  localparam logic [7:0]  HEADER_TYPE_VAL = 8'h00;
  localparam logic [31:0] BM_BASE_RESET   = 32'h00000001;
  localparam logic [15:0] TIMING_RESET    = 16'h0000;
  localparam logic [3:0]  LATENCY_RESET   = 4'h0;
  localparam logic [3:0]  BM_LOW_BITS     = 4'h1;

  // Timing register fields
  localparam int          DECODE_EN_BIT   = 15;
  localparam int          SLAVE_EN_BIT    = 14;
  localparam int          ISP_LSB         = 12;
  localparam int          RTC_LSB         = 8;
  // Writable bits: 11:10 reserved; 14 reserved on the earlier variant
  localparam logic [15:0] TIM_MASK_LATE   = 16'hF3FF;
  localparam logic [15:0] TIM_MASK_EARLY  = 16'hB3FF;

  // ATA register blocks
  localparam logic [15:0] PRI_CMD_BASE    = 16'h01F0;
  localparam logic [15:0] PRI_CTL_ADDR    = 16'h03F6;
  localparam logic [15:0] SEC_CMD_BASE    = 16'h0170;
  localparam logic [15:0] SEC_CTL_ADDR    = 16'h0376;

  // Sample point and recovery code to clock count
  function automatic logic [2:0] isp_clocks(input logic [1:0] code);
    isp_clocks = 3'h5 - {1'b0, code};
  endfunction : isp_clocks

  function automatic logic [2:0] rtc_clocks(input logic [1:0] code);
    rtc_clocks = 3'h4 - {1'b0, code};
  endfunction : rtc_clocks

endpackage : ide_cfg_pkg

// ===== ide_channel_timing.sv
/*
  Per-channel timing selection: picks the sample point and recovery
  of the selected drive and turns them into clock counts.
  Assumes drive select and slave codes come from same-clock logic.
*/
`timescale 1ns/1ps
module ide_channel_timing (
  input  wire logic [15:0] channel_timing_register,
  input  wire logic [3:0]  slave_code,
  input  wire logic        slave_selected,
  output logic      [2:0]  sample_clocks,
  output logic      [2:0]  recovery_clocks
);
  import ide_cfg_pkg::*;

  wire logic use_slave;
  wire logic [1:0] isp_code;
  wire logic [1:0] rtc_code;

  // Bit 14 is write-masked on the earlier variant, so it stays zero there
  assign use_slave = channel_timing_register[SLAVE_EN_BIT]
                     & slave_selected; // RULE_10
  assign isp_code  = use_slave ? slave_code[3:2]
                     : channel_timing_register[ISP_LSB +: 2]; // RULE_10
  assign rtc_code  = use_slave ? slave_code[1:0]
                     : channel_timing_register[RTC_LSB +: 2]; // RULE_10
  assign sample_clocks   = isp_clocks(isp_code); // RULE_11
  assign recovery_clocks = rtc_clocks(rtc_code); // RULE_12

endmodule : ide_channel_timing

// ===== ide_function_config_regs.sv
/*
  Configuration registers of the IDE function: burst latency limit,
  header type, bus-master I/O base and two channel timing registers,
  with the burst limiter and I/O decode they steer.
  Assumes single-cycle config strobes on ref_clk from the PCI target
  logic, and frame_active driven by the own bus-master logic.
*/
// Function
// RULE_01: A burst runs without limit while bus hold acknowledge stays asserted.
// RULE_02: After acknowledge negates the burst ends once bits 7:4 of the latency limit in clocks have passed; bits 3:0 are reserved.
// RULE_03: The header type byte is read-only and reads 00h.
// RULE_04: The bus-master base maps a 16-byte I/O window.
// RULE_05: Base bits 15:4 are writable and are compared with address bits 15:4.
// RULE_06: Base bits 31:16, 3:2 and reserved bit 1 read as zero.
// RULE_07: Base bit 0 reads as one and the base resets to 00000001h.
// RULE_08: Two 16-bit channel timing registers reset to 0000h.
// RULE_09: Bit 15 of a timing register claims that channel's ATA blocks, else they go subtractive.
// RULE_10: On the later variant bit 14 gives the slave drive its own timing.
// RULE_11: Sample point codes 00 to 11 give 5, 4, 3 and 2 clocks; bits 11:10 reserved.
// RULE_12: Recovery codes 00 to 11 give 4, 3, 2 and 1 clocks.
// RULE_13: The latency counter is cleared and held outside FRAME and counts during it.
// RULE_14: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
module ide_function_config_regs #(
  parameter bit LATER_VARIANT = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:2]  cfg_addr,
  input  wire logic [3:0]  cfg_byte_en,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rdata_valid,
  input  wire logic        io_cycle,
  input  wire logic [15:0] io_addr,
  output logic             bm_window_hit,
  output logic             primary_ide_hit,
  output logic             secondary_ide_hit,
  output logic             subtractive_decode,
  input  wire logic        frame_active,
  input  wire logic        bus_hold_ack_n,
  output logic             burst_stop,
  input  wire logic [7:0]  slave_timing_register,
  input  wire logic        primary_slave_selected,
  input  wire logic        secondary_slave_selected,
  output logic      [2:0]  primary_sample_clocks,
  output logic      [2:0]  primary_recovery_clocks,
  output logic      [2:0]  secondary_sample_clocks,
  output logic      [2:0]  secondary_recovery_clocks
);
  import ide_cfg_pkg::*;

  localparam logic [15:0] TIM_MASK =
    LATER_VARIANT ? TIM_MASK_LATE : TIM_MASK_EARLY;

  // Shared by both channels
  function automatic logic [7:0] lane_merge(input logic [7:0] old_byte,
                                            input logic [7:0] new_byte,
                                            input logic       enable);
    lane_merge = enable ? new_byte : old_byte;
  endfunction : lane_merge

  function automatic logic ata_block_hit(input logic [15:0] addr,
                                         input logic [15:0] cmd_base,
                                         input logic [15:0] ctl_addr);
    ata_block_hit = addr[15:3] == cmd_base[15:3] || addr == ctl_addr;
  endfunction : ata_block_hit

  logic [3:0]  latency_limit_reg;
  logic [11:0] bm_base_reg;
  logic [15:0] pri_tim_reg;
  logic [15:0] sec_tim_reg;
  logic [7:0]  lat_count_reg;
  logic [7:0]  lat_count_next;
  logic        hold_meta_reg;
  logic        hold_sync_reg;
  logic [31:0] rdata_next;

  wire logic        sel_lat;
  wire logic        sel_base;
  wire logic        sel_tim;
  wire logic [7:0]  lat_value;
  wire logic        lat_expired;
  wire logic [31:0] bm_base_view;
  wire logic [15:0] pri_tim_wr;
  wire logic [15:0] sec_tim_wr;
  wire logic        pri_cmd_hit;
  wire logic        sec_cmd_hit;
  wire logic        lat_wr_en;
  wire logic        base_lo_wr_en;
  wire logic        base_hi_wr_en;
  wire logic        tim_wr_en;

  assign sel_lat  = cfg_addr == LATENCY_OFS[7:2];
  assign sel_base = cfg_addr == BM_BASE_OFS[7:2];
  assign sel_tim  = cfg_addr == PRI_TIM_OFS[7:2];
  assign lat_wr_en     = cfg_wr && sel_lat && cfg_byte_en[1];
  assign base_lo_wr_en = cfg_wr && sel_base && cfg_byte_en[0];
  assign base_hi_wr_en = cfg_wr && sel_base && cfg_byte_en[1];
  // One dword carries both channels, so one strobe writes both
  assign tim_wr_en     = cfg_wr && sel_tim;

  // Byte-lane merges, reserved bits masked off
  assign pri_tim_wr = {lane_merge(pri_tim_reg[15:8], cfg_wdata[15:8],
                                  cfg_byte_en[1]),
                       lane_merge(pri_tim_reg[7:0], cfg_wdata[7:0],
                                  cfg_byte_en[0])} & TIM_MASK; // RULE_14
  assign sec_tim_wr = {lane_merge(sec_tim_reg[15:8], cfg_wdata[31:24],
                                  cfg_byte_en[3]),
                       lane_merge(sec_tim_reg[7:0], cfg_wdata[23:16],
                                  cfg_byte_en[2])} & TIM_MASK; // RULE_14

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latency_limit_reg <= LATENCY_RESET;
      bm_base_reg       <= BM_BASE_RESET[15:4]; // RULE_07
      pri_tim_reg       <= TIMING_RESET; // RULE_08
      sec_tim_reg       <= TIMING_RESET; // RULE_08
    end else begin
      if (lat_wr_en)
        latency_limit_reg <= cfg_wdata[15:12]; // RULE_02
      if (base_lo_wr_en)
        bm_base_reg[3:0] <= cfg_wdata[7:4]; // RULE_05
      if (base_hi_wr_en)
        bm_base_reg[11:4] <= cfg_wdata[15:8]; // RULE_05
      if (tim_wr_en) begin
        pri_tim_reg <= pri_tim_wr;
        sec_tim_reg <= sec_tim_wr;
      end
    end
  end

  // Fixed fields are wired, so writes cannot disturb them
  assign bm_base_view = {16'h0000, bm_base_reg, BM_LOW_BITS}; // RULE_06 RULE_07

  always_comb begin
    rdata_next = 32'h00000000;
    if (sel_lat)
      rdata_next = {8'h00, HEADER_TYPE_VAL, latency_limit_reg, 4'h0,
                    8'h00}; // RULE_03 RULE_14
    else if (sel_base)
      rdata_next = bm_base_view;
    else if (sel_tim)
      rdata_next = {sec_tim_reg, pri_tim_reg};
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_rdata       <= 32'h00000000;
      cfg_rdata_valid <= 1'b0;
    end else begin
      cfg_rdata_valid <= cfg_rd;
      if (cfg_rd)
        cfg_rdata <= rdata_next;
    end
  end

  // Pin comes from another domain: two flops before use
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_meta_reg <= 1'b1;
      hold_sync_reg <= 1'b1;
    end else begin
      hold_meta_reg <= bus_hold_ack_n;
      hold_sync_reg <= hold_meta_reg;
    end
  end

  // Counter follows frame_active only, so it needs no synchroniser
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      lat_count_reg <= 8'h00;
    else
      lat_count_reg <= lat_count_next; // RULE_13
  end

  // Saturates so a long hold does not wrap and re-arm the slice
  assign lat_value = {latency_limit_reg, 4'h0};
  assign lat_expired = lat_count_reg >= lat_value;
  always_comb begin
    lat_count_next = 8'h00; // RULE_13
    if (frame_active)
      lat_count_next = lat_expired ? lat_count_reg
                       : lat_count_reg + 8'h01; // RULE_13
  end

  assign burst_stop = frame_active && lat_expired
                      && hold_sync_reg; // RULE_01 RULE_02

  // I/O decode
  // Base of zero still decodes; gating lives outside this block
  assign bm_window_hit = io_cycle
                         && io_addr[15:4] == bm_base_reg; // RULE_04 RULE_05
  assign pri_cmd_hit = ata_block_hit(io_addr, PRI_CMD_BASE, PRI_CTL_ADDR);
  assign sec_cmd_hit = ata_block_hit(io_addr, SEC_CMD_BASE, SEC_CTL_ADDR);
  assign primary_ide_hit = io_cycle && pri_cmd_hit
                           && pri_tim_reg[DECODE_EN_BIT]; // RULE_09
  assign secondary_ide_hit = io_cycle && sec_cmd_hit
                             && sec_tim_reg[DECODE_EN_BIT]; // RULE_09
  assign subtractive_decode = io_cycle && !primary_ide_hit
                              && !secondary_ide_hit
                              && !bm_window_hit; // RULE_09

  ide_channel_timing u_pri_timing (
    .channel_timing_register (pri_tim_reg),
    .slave_code              (slave_timing_register[3:0]),
    .slave_selected          (primary_slave_selected),
    .sample_clocks           (primary_sample_clocks),
    .recovery_clocks         (primary_recovery_clocks)
  );

  ide_channel_timing u_sec_timing (
    .channel_timing_register (sec_tim_reg),
    .slave_code              (slave_timing_register[7:4]),
    .slave_selected          (secondary_slave_selected),
    .sample_clocks           (secondary_sample_clocks),
    .recovery_clocks         (secondary_recovery_clocks)
  );

endmodule : ide_function_config_regs

// ===== pci_host_model.sv
/*
  PCI host side: config strobes of one cycle each, and I/O addresses with io_cycle left high after the first.
  Assumes the bench calls the tasks after reset has been released.
*/
`timescale 1ns/1ps
module pci_host_model (
  input  wire logic        ref_clk,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rdata_valid,
  output logic             cfg_wr = 1'b0,
  output logic             cfg_rd = 1'b0,
  output logic      [7:2]  cfg_addr = 6'h00,
  output logic      [3:0]  cfg_byte_en = 4'hF,
  output logic      [31:0] cfg_wdata = 32'h00000000,
  output logic             io_cycle = 1'b0,
  output logic      [15:0] io_addr = 16'h0000
);
  task automatic wr(input logic [7:2] a, input logic [31:0] d);
    wr_be(a, d, 4'hF);
  endtask : wr
  task automatic wr_be(input logic [7:2] a, input logic [31:0] d,
                       input logic [3:0] be);
    @(posedge ref_clk);
    #1 cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_byte_en = be;
    @(posedge ref_clk);
    #1 cfg_wr = 1'b0;
    cfg_wdata = ~d;  // Released bus must not look valid
  endtask : wr_be
  task automatic rd(input logic [7:2] a, output logic [31:0] d);
    @(posedge ref_clk);
    #1 cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge ref_clk);
    #1 cfg_rd = 1'b0;
    d = (cfg_rdata_valid === 1'b1) ? cfg_rdata : 32'hDEADBEEF;
  endtask : rd
  task automatic io(input logic [15:0] a);
    @(posedge ref_clk);
    #1 io_cycle = 1'b1;
    io_addr = a;
    #1;
  endtask : io
endmodule : pci_host_model

// ===== test_ide_function_config_regs.sv
/*
  Self-checking bench for the IDE function config registers.
  Assumes pci_host_model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module test_ide_function_config_regs;
  import ide_cfg_pkg::*;
  logic        ref_clk = 1'b0, rst = 1'b1, frame_active = 1'b0;
  logic        bus_hold_ack_n = 1'b1, primary_slave_selected = 1'b0;
  logic        secondary_slave_selected = 1'b0;
  logic [7:0]  slave_timing_register = 8'h0C;
  logic        cfg_wr, cfg_rd, cfg_rdata_valid, io_cycle, burst_stop;
  logic        bm_window_hit, primary_ide_hit, secondary_ide_hit;
  logic        subtractive_decode;
  logic [7:2]  cfg_addr;
  logic [3:0]  cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  logic [15:0] io_addr;
  logic [2:0]  primary_sample_clocks, primary_recovery_clocks, sc, rc;
  int          num_errors = 0, tests_run = 0, cycles = 0;
  // Dword, write data, expected read back
  logic [69:0] rows [4] = '{{6'h08, 32'hFFFFFFFF, 32'h0000FFF1},
    {6'h10, 32'hFFFFFFFF, 32'hF3FFF3FF}, {6'h03, 32'hFFFFFFFF, 32'h0000F000},
    {6'h3F, 32'hFFFFFFFF, 32'h00000000}};

  ide_function_config_regs ide_function_config_regs_inst (.ref_clk, .rst,
    .cfg_wr, .cfg_rd, .cfg_addr, .cfg_byte_en, .cfg_wdata, .cfg_rdata,
    .cfg_rdata_valid, .io_cycle, .io_addr, .bm_window_hit, .primary_ide_hit,
    .secondary_ide_hit, .subtractive_decode, .frame_active, .bus_hold_ack_n,
    .burst_stop, .slave_timing_register, .primary_slave_selected,
    .secondary_slave_selected, .primary_sample_clocks,
    .primary_recovery_clocks, .secondary_sample_clocks(sc),
    .secondary_recovery_clocks(rc));
  pci_host_model pci_host_model_inst (.ref_clk, .cfg_rdata, .cfg_rdata_valid,
    .cfg_wr, .cfg_rd, .cfg_addr, .cfg_byte_en, .cfg_wdata, .io_cycle,
    .io_addr);

  always #2.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic final_report;
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // Whole run is about a hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    #1 rst = 1'b0;
    foreach (rows[i]) begin
      pci_host_model_inst.wr(rows[i][69:64], rows[i][63:32]);
      pci_host_model_inst.rd(rows[i][69:64], rd);
      chk(rd, rows[i][31:0]);
    end
    @(posedge ref_clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    pci_host_model_inst.rd(6'h08, rd);
    chk(rd, BM_BASE_RESET);
    pci_host_model_inst.rd(6'h10, rd);
    chk(rd, 32'h00000000);
    pci_host_model_inst.rd(6'h03, rd);
    chk(rd, 32'h00000000);
    pci_host_model_inst.wr(6'h08, 32'h00001230);
    pci_host_model_inst.wr(6'h10, 32'h00008000);
    pci_host_model_inst.io(16'h01F0);
    chk({primary_ide_hit, subtractive_decode}, 32'h2);
    pci_host_model_inst.io(16'h03F6);
    chk({primary_ide_hit, subtractive_decode}, 32'h2);
    pci_host_model_inst.io(16'h0170);
    chk({secondary_ide_hit, subtractive_decode}, 32'h1);
    pci_host_model_inst.io(16'h123F);
    chk(bm_window_hit, 32'h1);
    pci_host_model_inst.io(16'h1240);
    chk(bm_window_hit, 32'h0);
    for (int c = 0; c < 4; c++) begin
      pci_host_model_inst.wr(6'h10, {18'h0, c[1:0], 2'h0, c[1:0], 8'h00});
      chk(primary_sample_clocks, 32'(5 - c));
      chk(primary_recovery_clocks, 32'(4 - c));
    end
    primary_slave_selected = 1'b1;
    pci_host_model_inst.wr(6'h10, 32'h00004000);
    chk(primary_sample_clocks, 32'h2);
    pci_host_model_inst.wr(6'h10, 32'h00000000);
    chk(primary_sample_clocks, 32'h5);
    secondary_slave_selected = 1'b1;
    slave_timing_register = 8'h50;
    pci_host_model_inst.wr_be(6'h10, 32'h4000FFFF, 4'hC);
    chk(sc, 32'h4);
    chk(rc, 32'h3);
    pci_host_model_inst.rd(6'h10, rd);
    chk(rd, 32'h40000000);
    secondary_slave_selected = 1'b0;
    #1 chk(sc, 32'h5);
    chk(rc, 32'h4);
    // Limit 1 means a sixteen-clock slice
    pci_host_model_inst.wr(6'h03, 32'h00001000);
    frame_active = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 chk(burst_stop, 32'h0);
    repeat (10) @(posedge ref_clk);
    #1 chk(burst_stop, 32'h1);
    bus_hold_ack_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk(burst_stop, 32'h0);
    bus_hold_ack_n = 1'b1;
    frame_active = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk(burst_stop, 32'h0);
    final_report();
  end
endmodule : test_ide_function_config_regs
